/* src/tmpc_map.vh */
`ifndef TMPC_MAP_VH
`define TMPC_MAP_VH

// Register indices; the APB byte address is four times the index
`define TMPC_IDX_CPM_LOW 6'h1e
`define TMPC_IDX_CPM_HIGH 6'h1f
`define TMPC_IDX_SEL_HI 6'h23
`define TMPC_IDX_FIRST_TRIGGER_TERMINAL 6'h24
`define TMPC_IDX_SECOND_TRIGGER_TERMINAL 6'h25
`define TMPC_IDX_MOD 6'h26
`define TMPC_IDX_MULTIPLEXED_OUTPUT_TERMINAL 6'h27
`define TMPC_IDX_STATUS 6'h28
`define TMPC_ADDR(idx) {idx, 2'b00}

// Field positions
`define TMPC_DRV_MSB 2
`define TMPC_DRV_LSB 0
`define TMPC_SEL_LO_MSB 7
`define TMPC_SEL_LO_LSB 3
`define TMPC_THR_MSB 5
`define TMPC_THR_LSB 0
`define TMPC_FLAG_BIT 6
`define TMPC_SELHI_W 4
`define TMPC_STAT_LOCK_BIT 3
`define TMPC_STAT_MUX_BIT 4

// Reset values
`define TMPC_FIRST_TRIGGER_TERMINAL_CFG_RST 8'h08
`define TMPC_SECOND_TRIGGER_TERMINAL_CFG_RST 8'h10
`define TMPC_MOD_CFG_RST 8'h18
`define TMPC_MULTIPLEXED_OUTPUT_TERMINAL_CFG_RST 8'h38
`define TMPC_SEL_HI_RST 4'h0
`define TMPC_THR_LOW_RST 6'h0a
`define TMPC_THR_HIGH_RST 6'h32

// Drive-state codes
`define TMPC_DRV_TRISTATE 3'h0
`define TMPC_DRV_OPEN_DRAIN 3'h1
`define TMPC_DRV_PUSH_PULL 3'h2
`define TMPC_DRV_RESERVED 3'h3
`define TMPC_DRV_GROUND 3'h4
`define TMPC_DRV_INV_OPEN_DRAIN 3'h5
`define TMPC_DRV_INV_PUSH_PULL 3'h6
`define TMPC_DRV_INPUT 3'h7

// Source-selection codes
`define TMPC_SEL_GROUND 6'h00
`define TMPC_SEL_SYNC_T1 6'h04
`define TMPC_SEL_SYNC_T2 6'h05
`define TMPC_SEL_SYNC_MOD 6'h06
`define TMPC_SEL_READBACK 6'h07
`define TMPC_SEL_RAMP_COMPARATOR_ZERO 6'h08
`define TMPC_SEL_RAMP_COMPARATOR_ONE 6'h09
`define TMPC_SEL_LOCK 6'h0a
`define TMPC_SEL_DLOCK 6'h0b
`define TMPC_SEL_CPM_GOOD 6'h0c
`define TMPC_SEL_CPM_HIGH 6'h0d
`define TMPC_SEL_CPM_LOW 6'h0e
`define TMPC_SEL_RAMP_LIM 6'h0f
`define TMPC_SEL_REF_DIV2 6'h10
`define TMPC_SEL_REF_DIV4 6'h11
`define TMPC_SEL_FB_DIV2 6'h12
`define TMPC_SEL_FB_DIV4 6'h13
`define TMPC_SEL_RAMP_COMPARATOR_ZERO_RAMP 6'h16
`define TMPC_SEL_RAMP_COMPARATOR_ONE_RAMP 6'h17
`define TMPC_SEL_FAST_LOCK 6'h1c
`define TMPC_SEL_CP_GAIN 6'h1d
`define TMPC_SEL_FLAG0 6'h1e
`define TMPC_SEL_FLAG1 6'h1f
`define TMPC_SEL_TRIG_A 6'h20
`define TMPC_SEL_TRIG_B 6'h21
`define TMPC_SEL_TRIG_C 6'h22
`define TMPC_SEL_REF_DIV 6'h23
`define TMPC_SEL_CP_UP 6'h24
`define TMPC_SEL_CP_DOWN 6'h25
`define TMPC_SEL_RAMP_DONE 6'h26

`endif

/* src/tmpc_top.v */
`timescale 1ns/1ps
`include "tmpc_map.vh"

module tmpc_top (
    input wire core_clk,
    input wire rst_b,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire first_trigger_terminal_in,
    output wire first_trigger_terminal_out,
    output wire first_trigger_terminal_oe,
    input wire second_trigger_terminal_in,
    output wire second_trigger_terminal_out,
    output wire second_trigger_terminal_oe,
    input wire modulation_terminal_in,
    output wire modulation_terminal_out,
    output wire modulation_terminal_oe,
    input wire multiplexed_output_terminal_in,
    output wire multiplexed_output_terminal_out,
    output wire multiplexed_output_terminal_oe,
    output reg first_trigger_level,
    output reg second_trigger_level,
    output reg modulation_level,
    input wire readback_data,
    input wire ramp_comparator_zero,
    input wire ramp_comparator_one,
    input wire digital_lock,
    input wire [5:0] cp_voltage_code,
    input wire ramp_limit_exceeded,
    input wire ref_div_out,
    input wire fb_div_out,
    input wire ramp_comparator_zero_qual,
    input wire ramp_comparator_one_qual,
    input wire fast_lock_active,
    input wire charge_pump_gain,
    input wire ramp_flag_zero,
    input wire ramp_flag_one,
    input wire internal_trigger_a,
    input wire internal_trigger_b,
    input wire internal_trigger_c,
    input wire charge_pump_up_pulse,
    input wire charge_pump_down_pulse,
    input wire ramp_count_finished
);

    // Terminal order: 0 first trigger, 1 second trigger, 2 modulation, 3 mux out
    reg [7:0] cfg [0:3];
    reg [3:0] sel_hi;
    reg [5:0] thr_low;
    reg [5:0] thr_high;
    reg [3:0] pin_out;
    reg [3:0] pin_oe;
    reg [3:0] sync_meta;
    reg [3:0] sync_level;
    reg ref_prev;
    reg fb_prev;
    reg [1:0] ref_cnt;
    reg [1:0] fb_cnt;
    reg [63:0] src;
    reg [3:0] next_pin_out;
    reg [3:0] next_pin_oe;
    reg [31:0] next_prdata;
    reg next_pslverr;
    reg [1:0] drv;
    reg [5:0] sel;
    integer i;

    wire [3:0] term_in;
    wire cpm_low;
    wire cpm_high;
    wire cpm_good;
    wire combined_lock;
    wire setup_phase;
    wire wr_en;

    // Drive-state decode: returns {pin level, output enable}
    function [1:0] drive_pin;
        input [2:0] state;
        input s;
        begin
            case (state)
                `TMPC_DRV_OPEN_DRAIN: begin
                    drive_pin = {1'b0, ~s};
                end
                `TMPC_DRV_PUSH_PULL: begin
                    drive_pin = {s, 1'b1};
                end
                `TMPC_DRV_GROUND: begin
                    drive_pin = {1'b0, 1'b1};
                end
                `TMPC_DRV_INV_OPEN_DRAIN: begin
                    drive_pin = {1'b0, s};
                end
                `TMPC_DRV_INV_PUSH_PULL: begin
                    drive_pin = {~s, 1'b1};
                end
                default: begin
                    // Tristate, reserved and input leave the pin released
                    drive_pin = 2'h0;
                end
            endcase
        end
    endfunction

    // Full 6-bit selection of one terminal
    function [5:0] full_sel;
        input hi;
        input [7:0] c;
        begin
            full_sel = {hi, c[`TMPC_SEL_LO_MSB:`TMPC_SEL_LO_LSB]};
        end
    endfunction

    assign term_in = {multiplexed_output_terminal_in, modulation_terminal_in, second_trigger_terminal_in,
        first_trigger_terminal_in};

    // Pins come straight from the output flops
    assign first_trigger_terminal_out = pin_out[0];
    assign first_trigger_terminal_oe = pin_oe[0];
    assign second_trigger_terminal_out = pin_out[1];
    assign second_trigger_terminal_oe = pin_oe[1];
    assign modulation_terminal_out = pin_out[2];
    assign modulation_terminal_oe = pin_oe[2];
    assign multiplexed_output_terminal_out = pin_out[3];
    assign multiplexed_output_terminal_oe = pin_oe[3];

    // Charge pump window check against the programmed thresholds
    assign cpm_low = cp_voltage_code < thr_low;
    assign cpm_high = cp_voltage_code > thr_high;
    assign cpm_good = ~cpm_low & ~cpm_high;
    assign combined_lock = digital_lock & cpm_good;

    // APB phases; writes land on the access edge only
    assign setup_phase = psel & ~penable;
    assign wr_en = psel & penable & pready & pwrite;

    // Two-flop synchronizers for all four terminals; the mux-out one feeds status only
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            sync_meta <= 4'h0;
            sync_level <= 4'h0;
        end else begin
            sync_meta <= term_in;
            sync_level <= sync_meta;
        end
    end

    // Levels handed to the ramp engine, only while the terminal is an input
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            first_trigger_level <= 1'b0;
            second_trigger_level <= 1'b0;
            modulation_level <= 1'b0;
        end else begin
            first_trigger_level <= sync_level[0] & (cfg[0][`TMPC_DRV_MSB:`TMPC_DRV_LSB] == `TMPC_DRV_INPUT);
            second_trigger_level <= sync_level[1] & (cfg[1][`TMPC_DRV_MSB:`TMPC_DRV_LSB] == `TMPC_DRV_INPUT);
            modulation_level <= sync_level[2] & (cfg[2][`TMPC_DRV_MSB:`TMPC_DRV_LSB] == `TMPC_DRV_INPUT);
        end
    end

    // Divide-by-2 and divide-by-4 of both divider outputs, counted on rising edges
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            ref_prev <= 1'b0;
            fb_prev <= 1'b0;
            ref_cnt <= 2'h0;
            fb_cnt <= 2'h0;
        end else begin
            ref_prev <= ref_div_out;
            fb_prev <= fb_div_out;
            if (ref_div_out & ~ref_prev) begin
                ref_cnt <= ref_cnt + 2'h1;
            end
            if (fb_div_out & ~fb_prev) begin
                fb_cnt <= fb_cnt + 2'h1;
            end
        end
    end

    // Source table; codes not listed, reserved ones included, read as ground
    always @* begin
        src = 64'h0;
        src[`TMPC_SEL_GROUND] = 1'b0;
        src[`TMPC_SEL_SYNC_T1] = sync_level[0];
        src[`TMPC_SEL_SYNC_T2] = sync_level[1];
        src[`TMPC_SEL_SYNC_MOD] = sync_level[2];
        src[`TMPC_SEL_READBACK] = readback_data;
        src[`TMPC_SEL_RAMP_COMPARATOR_ZERO] = ramp_comparator_zero;
        src[`TMPC_SEL_RAMP_COMPARATOR_ONE] = ramp_comparator_one;
        src[`TMPC_SEL_LOCK] = combined_lock;
        src[`TMPC_SEL_DLOCK] = digital_lock;
        src[`TMPC_SEL_CPM_GOOD] = cpm_good;
        src[`TMPC_SEL_CPM_HIGH] = cpm_high;
        src[`TMPC_SEL_CPM_LOW] = cpm_low;
        src[`TMPC_SEL_RAMP_LIM] = ramp_limit_exceeded;
        src[`TMPC_SEL_REF_DIV2] = ref_cnt[0];
        src[`TMPC_SEL_REF_DIV4] = ref_cnt[1];
        src[`TMPC_SEL_FB_DIV2] = fb_cnt[0];
        src[`TMPC_SEL_FB_DIV4] = fb_cnt[1];
        src[`TMPC_SEL_RAMP_COMPARATOR_ZERO_RAMP] = ramp_comparator_zero_qual;
        src[`TMPC_SEL_RAMP_COMPARATOR_ONE_RAMP] = ramp_comparator_one_qual;
        src[`TMPC_SEL_FAST_LOCK] = fast_lock_active;
        src[`TMPC_SEL_CP_GAIN] = charge_pump_gain;
        src[`TMPC_SEL_FLAG0] = ramp_flag_zero;
        src[`TMPC_SEL_FLAG1] = ramp_flag_one;
        src[`TMPC_SEL_TRIG_A] = internal_trigger_a;
        src[`TMPC_SEL_TRIG_B] = internal_trigger_b;
        src[`TMPC_SEL_TRIG_C] = internal_trigger_c;
        src[`TMPC_SEL_REF_DIV] = ref_div_out;
        src[`TMPC_SEL_CP_UP] = charge_pump_up_pulse;
        src[`TMPC_SEL_CP_DOWN] = charge_pump_down_pulse;
        src[`TMPC_SEL_RAMP_DONE] = ramp_count_finished;
    end

    // Per-terminal selection and drive; input codes 1..3 give ground
    always @* begin
        next_pin_out = 4'h0;
        next_pin_oe = 4'h0;
        drv = 2'h0;
        sel = 6'h0;
        for (i = 0; i < 4; i = i + 1) begin
            sel = full_sel(sel_hi[i], cfg[i]);
            drv = drive_pin(cfg[i][`TMPC_DRV_MSB:`TMPC_DRV_LSB], src[sel]);
            next_pin_out[i] = drv[1];
            next_pin_oe[i] = drv[0];
        end
    end

    // Output flops for all four terminals
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            pin_out <= 4'h0;
            pin_oe <= 4'h0;
        end else begin
            pin_out <= next_pin_out;
            pin_oe <= next_pin_oe;
        end
    end

    // Read mux, prepared during the setup phase
    always @* begin
        next_prdata = 32'h0;
        next_pslverr = 1'b0;
        case (paddr)
            `TMPC_ADDR(`TMPC_IDX_CPM_LOW): begin
                next_prdata[`TMPC_THR_MSB:`TMPC_THR_LSB] = thr_low;
                next_prdata[`TMPC_FLAG_BIT] = ~cpm_low;
            end
            `TMPC_ADDR(`TMPC_IDX_CPM_HIGH): begin
                next_prdata[`TMPC_THR_MSB:`TMPC_THR_LSB] = thr_high;
                next_prdata[`TMPC_FLAG_BIT] = cpm_high;
            end
            `TMPC_ADDR(`TMPC_IDX_SEL_HI): begin
                next_prdata[3:0] = sel_hi;
            end
            `TMPC_ADDR(`TMPC_IDX_FIRST_TRIGGER_TERMINAL): begin
                next_prdata[7:0] = cfg[0];
            end
            `TMPC_ADDR(`TMPC_IDX_SECOND_TRIGGER_TERMINAL): begin
                next_prdata[7:0] = cfg[1];
            end
            `TMPC_ADDR(`TMPC_IDX_MOD): begin
                next_prdata[7:0] = cfg[2];
            end
            `TMPC_ADDR(`TMPC_IDX_MULTIPLEXED_OUTPUT_TERMINAL): begin
                next_prdata[7:0] = cfg[3];
            end
            `TMPC_ADDR(`TMPC_IDX_STATUS): begin
                next_prdata[2:0] = sync_level[2:0];
                next_prdata[`TMPC_STAT_MUX_BIT] = sync_level[3];
                next_prdata[`TMPC_STAT_LOCK_BIT] = combined_lock;
            end
            default: begin
                next_pslverr = 1'b1;
            end
        endcase
    end

    // APB answer: one access cycle, ready always on the first access edge
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0;
        end else begin
            pready <= setup_phase;
            if (setup_phase) begin
                pslverr <= next_pslverr;
                prdata <= pwrite ? 32'h0 : next_prdata;
            end else begin
                pslverr <= 1'b0;
                prdata <= 32'h0;
            end
        end
    end

    // Register writes; read-only flags and the status word ignore writes
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            cfg[0] <= `TMPC_FIRST_TRIGGER_TERMINAL_CFG_RST;
            cfg[1] <= `TMPC_SECOND_TRIGGER_TERMINAL_CFG_RST;
            cfg[2] <= `TMPC_MOD_CFG_RST;
            cfg[3] <= `TMPC_MULTIPLEXED_OUTPUT_TERMINAL_CFG_RST;
            sel_hi <= `TMPC_SEL_HI_RST;
            thr_low <= `TMPC_THR_LOW_RST;
            thr_high <= `TMPC_THR_HIGH_RST;
        end else if (wr_en) begin
            case (paddr)
                `TMPC_ADDR(`TMPC_IDX_CPM_LOW): begin
                    thr_low <= pwdata[`TMPC_THR_MSB:`TMPC_THR_LSB];
                end
                `TMPC_ADDR(`TMPC_IDX_CPM_HIGH): begin
                    thr_high <= pwdata[`TMPC_THR_MSB:`TMPC_THR_LSB];
                end
                `TMPC_ADDR(`TMPC_IDX_SEL_HI): begin
                    sel_hi <= pwdata[`TMPC_SELHI_W-1:0];
                end
                `TMPC_ADDR(`TMPC_IDX_FIRST_TRIGGER_TERMINAL): begin
                    cfg[0] <= pwdata[7:0];
                end
                `TMPC_ADDR(`TMPC_IDX_SECOND_TRIGGER_TERMINAL): begin
                    cfg[1] <= pwdata[7:0];
                end
                `TMPC_ADDR(`TMPC_IDX_MOD): begin
                    cfg[2] <= pwdata[7:0];
                end
                `TMPC_ADDR(`TMPC_IDX_MULTIPLEXED_OUTPUT_TERMINAL): begin
                    cfg[3] <= pwdata[7:0];
                end
                default: begin
                    sel_hi <= sel_hi;
                end
            endcase
        end
    end

endmodule // tmpc_top

/* verif/tmpc_pin_model.sv */
`timescale 1ns/1ps
// Far-side logic on the four terminals; each terminal has a board pull-up
module tmpc_pin_model (
    input wire [3:0] out,
    input wire [3:0] oe,
    input wire [3:0] ext_en,
    input wire [3:0] ext_val,
    output wire [3:0] pin
);
    // Device drive wins, outside logic drives only released terminals, else the pull-up
    assign pin = (oe & out) | (~oe & ext_en & ext_val) | (~oe & ~ext_en);
endmodule // tmpc_pin_model

/* verif/tmpc_properties.sv */
`timescale 1ns/1ps
// Bus handshake and terminal synchronizer checks
module tmpc_checker (
    input wire core_clk,
    input wire rst_b,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire first_trigger_terminal_in,
    input wire first_trigger_level
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_b);
    // Mapped register addresses
    wire mapped = paddr inside {8'h78, 8'h7c, 8'h8c, 8'h90, 8'h94, 8'h98, 8'h9c, 8'ha0};
    a_ready_after_setup: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("ready held too long");
    a_ready_in_access: assert property (pready |-> psel && penable)
        else $error("ready outside access");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    a_idle_data_zero: assert property (!pready |-> prdata == 32'h0)
        else $error("read data not zero while idle");
    a_unmapped_error: assert property (pready && !mapped |-> pslverr)
        else $error("unmapped access not refused");
    a_mapped_no_error: assert property (pready && mapped |-> !pslverr)
        else $error("mapped access refused");
    a_level_follows_pin: assert property ($rose(first_trigger_level) |-> $past(first_trigger_terminal_in, 3))
        else $error("trigger level rose without pin");
    cover property (pready && pslverr);
    cover property (pready && pwrite && mapped);
    cover property ($rose(first_trigger_level));
endmodule // tmpc_checker

bind tmpc_top tmpc_checker u_chk (.core_clk(core_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .first_trigger_terminal_in(first_trigger_terminal_in), .first_trigger_level(first_trigger_level));

/* verif/testbench.sv */
`timescale 1ns/1ps
module testbench;
    reg core_clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0, er;
    reg [7:0] paddr = 8'h00;
    reg [31:0] pwdata = 32'h0, rd;
    reg [63:0] srcv = 64'h0;
    reg [5:0] cpv = 6'h00;
    reg [3:0] ext_en = 4'h0, ext_val = 4'h0, shi = 4'h0;
    wire [31:0] prdata;
    wire pready, pslverr;
    wire [3:0] t_out, t_oe, pin;
    wire [2:0] lvl;
    integer n_errors = 0, tests_run = 0, i, j, k, s;
    int cv[5] = '{5, 10, 20, 50, 51};
    int sv[4] = '{10, 12, 13, 14};
    reg lo, hi;
    tmpc_pin_model far (.out(t_out), .oe(t_oe), .ext_en(ext_en), .ext_val(ext_val), .pin(pin));
    tmpc_top dut (.core_clk(core_clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .first_trigger_terminal_in(pin[0]), .first_trigger_terminal_out(t_out[0]), .first_trigger_terminal_oe(t_oe[0]),
        .second_trigger_terminal_in(pin[1]), .second_trigger_terminal_out(t_out[1]), .second_trigger_terminal_oe(t_oe[1]),
        .modulation_terminal_in(pin[2]), .modulation_terminal_out(t_out[2]), .modulation_terminal_oe(t_oe[2]),
        .multiplexed_output_terminal_in(pin[3]), .multiplexed_output_terminal_out(t_out[3]),
        .multiplexed_output_terminal_oe(t_oe[3]), .first_trigger_level(lvl[0]), .second_trigger_level(lvl[1]),
        .modulation_level(lvl[2]), .readback_data(srcv[7]), .ramp_comparator_zero(srcv[8]),
        .ramp_comparator_one(srcv[9]), .digital_lock(srcv[11]), .cp_voltage_code(cpv),
        .ramp_limit_exceeded(srcv[15]), .ref_div_out(srcv[35]), .fb_div_out(srcv[18]),
        .ramp_comparator_zero_qual(srcv[22]), .ramp_comparator_one_qual(srcv[23]), .fast_lock_active(srcv[28]),
        .charge_pump_gain(srcv[29]), .ramp_flag_zero(srcv[30]), .ramp_flag_one(srcv[31]),
        .internal_trigger_a(srcv[32]), .internal_trigger_b(srcv[33]), .internal_trigger_c(srcv[34]),
        .charge_pump_up_pulse(srcv[36]), .charge_pump_down_pulse(srcv[37]), .ramp_count_finished(srcv[38]));
    // Clock generator
    initial begin
        forever #5 core_clk = ~core_clk;
    end
    task check(input string nm, input [31:0] seen, input [31:0] exp);
        tests_run = tests_run + 1;
        if (seen !== exp) begin
            n_errors = n_errors + 1;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task report_and_stop;
        $display("Checks %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // One bus transfer; request held until ready is sampled high
    task apb(input w, input [7:0] a, input [31:0] d);
        integer t;
        t = 0;
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        while (pready !== 1'b1) begin
            t = t + 1;
            if (t > 16) begin
                n_errors = n_errors + 1;
                report_and_stop;
            end
            @(posedge core_clk);
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task rdc(input [7:0] a, input [31:0] exp);
        apb(1'b0, a, 32'h0);
        check("register", rd, exp);
    endtask
    // Program one terminal, then let the outputs settle
    task cfg(input [1:0] t, input [5:0] sel, input [2:0] drv);
        shi[t] = sel[5];
        apb(1'b1, 8'h90 + {4'h0, t, 2'b00}, {24'h0, sel[4:0], drv});
        apb(1'b1, 8'h8c, {28'h0, shi});
        repeat (3) @(posedge core_clk);
    endtask
    function [1:0] drv_exp(input [2:0] c, input b);
        case (c)
            3'h1: drv_exp = {~b, 1'b0};
            3'h2: drv_exp = {1'b1, b};
            3'h4: drv_exp = 2'b10;
            3'h5: drv_exp = {b, 1'b0};
            3'h6: drv_exp = {1'b1, ~b};
            default: drv_exp = 2'b00;
        endcase
    endfunction
    // Pulse a divider input n times; the divided output must toggle
    task divc(input [5:0] sl, input integer b, input integer n);
        cfg(2'd3, sl, 3'h2);
        lo = t_out[3];
        repeat (n) begin
            srcv[b] <= 1'b1;
            @(posedge core_clk);
            srcv[b] <= 1'b0;
            @(posedge core_clk);
        end
        repeat (3) @(posedge core_clk);
        check("divider", t_out[3], !lo);
    endtask
    // Main sequence
    initial begin
        repeat (6) @(posedge core_clk);
        rst_b <= 1'b1;
        check("oe", t_oe, 4'h0);
        rdc(8'h90, 32'h08);
        rdc(8'h94, 32'h10);
        rdc(8'h98, 32'h18);
        rdc(8'h9c, 32'h38);
        rdc(8'h8c, 32'h0);
        rdc(8'h78, 32'h0a);
        rdc(8'h7c, 32'h32);
        rdc(8'h80, 32'h0);
        check("slverr", er, 1'b1);
        $display("Test reset done");
        for (j = 0; j < 4; j++) begin
            for (k = 0; k < 8; k++) begin
                for (s = 0; s < 2; s++) begin
                    srcv[7] <= s[0];
                    cfg(j[1:0], 6'd7, k[2:0]);
                    check("drive", {t_oe[j], t_out[j] & t_oe[j]}, drv_exp(k[2:0], s[0]));
                    check("pin", pin[j], drv_exp(k[2:0], s[0]) != 2'b10);
                end
                rdc(8'h90 + {4'h0, j[1:0], 2'b00}, {24'h0, 5'd7, k[2:0]});
            end
        end
        $display("Test drive done");
        for (i = 0; i < 64; i++) begin
            if (!(i inside {[4:6], 10, [12:19]})) begin
                s = i inside {[7:9], 11, 15, 22, 23, [28:38]};
                srcv <= s ? 64'h1 << i : ~64'h0;
                cfg(2'd3, i[5:0], 3'h2);
                check("select", t_out[3], s);
                if (s) begin
                    srcv <= ~(64'h1 << i);
                    repeat (3) @(posedge core_clk);
                    check("select", t_out[3], 1'b0);
                end
            end
        end
        $display("Test select done");
        srcv <= 64'h800;
        for (i = 0; i < 5; i++) begin
            cpv <= cv[i][5:0];
            lo = cv[i] < 6'h0a;
            hi = cv[i] > 6'h32;
            for (k = 0; k < 4; k++) begin
                cfg(2'd3, sv[k][5:0], 3'h2);
                check("monitor", t_out[3], k == 3 ? lo : k == 2 ? hi : !(lo || hi));
            end
        end
        apb(1'b1, 8'h78, 32'h20);
        cpv <= 6'd20;
        cfg(2'd3, 6'd10, 3'h2);
        check("lock", t_out[3], 1'b0);
        rdc(8'h78, 32'h20);
        srcv <= 64'h0;
        apb(1'b1, 8'h78, 32'h0a);
        cfg(2'd3, 6'd10, 3'h2);
        check("lock", t_out[3], 1'b0);
        divc(6'd16, 35, 1);
        divc(6'd17, 35, 2);
        divc(6'd18, 18, 1);
        divc(6'd19, 18, 2);
        $display("Test monitor done");
        ext_en <= 4'h7;
        ext_val <= 4'h0;
        for (k = 0; k < 3; k++) begin
            cfg(k[1:0], k[5:0] + 6'd1, 3'h7);
            cfg(2'd3, k[5:0] + 6'd4, 3'h2);
            check("sync", {lvl, t_out[3]}, ((1 << k) - 1) << 1);
            ext_val[k] <= 1'b1;
            repeat (5) @(posedge core_clk);
            check("sync", {lvl, t_out[3]}, (((2 << k) - 1) << 1) | 1);
        end
        rdc(8'h9c, 32'h32);
        rdc(8'ha0, 32'h17);
        $display("Test input done");
        report_and_stop;
    end
endmodule // testbench
